// ===== inc/hcpp_pkg.sv
// Constants and types shared by the host controlled pin port
package hcpp_pkg;
  // Pin counts and widths
  localparam int GPIO_NUM = 7;
  localparam int UART_NUM = 4;
  localparam int ALT_NUM = 4;
  localparam int DIV_W = 8;
  localparam int CNT_W = 16;
  // Alternate function pin positions
  localparam int PIN_TX_ACT = 0;
  localparam int PIN_RX_ACT = 1;
  localparam int PIN_XCVR_DIR = 2;
  localparam int PIN_WAKE = 3;
  // Reset values
  localparam logic [GPIO_NUM-1:0] LATCH_RST = 7'h7f;
  localparam logic [UART_NUM-1:0] UART_RST = 4'hf;
  localparam logic [ALT_NUM-1:0] ALT_RST = 4'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TOGGLE_HALF_NS = 20000;
  localparam int TOGGLE_CYCLES_RAW = TOGGLE_HALF_NS / CLK_PERIOD_NS;
  localparam int TOGGLE_CYCLES = (TOGGLE_CYCLES_RAW < 1) ? 1
                                 : TOGGLE_CYCLES_RAW;
  localparam logic [CNT_W-1:0] TOGGLE_LAST = CNT_W'(TOGGLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  // Bus side state of the latch logic
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SUSPENDED = 2'b10
  } hcpp_state_t;
  // Attached port type from data line detection
  typedef enum logic [1:0] {
    CHG_NONE = 2'b00,
    CHG_SDP = 2'b01,
    CHG_CDP = 2'b10,
    CHG_DCP = 2'b11
  } hcpp_chg_t;
endpackage : hcpp_pkg

// ===== design/hcpp_sync3.sv
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hcpp_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_reg; // First stage, read only by the second
  logic [W-1:0] s2_reg; // Second stage
  logic [W-1:0] s3_reg; // Third stage
  logic [W-1:0] level_reg; // Accepted level
  logic [W-1:0] agree; // Per bit agreement of stages two and three

  assign agree = ~(s2_reg ^ s3_reg);
  assign level_o = level_reg;

  // Chain; a new level counts only once two settled stages agree
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= (agree & s3_reg) | (~agree & level_reg);
    end
  end
endmodule : hcpp_sync3

// ===== design/hcpp_pin_port.sv
// Host controlled pin port: latches, drive modes, alternates, charger
`timescale 1ns/1ps
module hcpp_pin_port (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // Host latch access
  input wire logic LATCH_WR_I,
  input wire logic [hcpp_pkg::GPIO_NUM-1:0] LATCH_WDATA_I,
  output logic [hcpp_pkg::GPIO_NUM-1:0] LATCH_RDATA_O,
  output logic [hcpp_pkg::GPIO_NUM-1:0] PIN_LEVEL_O,
  // Configuration
  input wire logic [hcpp_pkg::GPIO_NUM-1:0] PP_MODE_I,
  input wire logic [hcpp_pkg::ALT_NUM-1:0] ALT_EN_I,
  input wire logic [hcpp_pkg::GPIO_NUM-1:0] RESET_LATCH_I,
  input wire logic [hcpp_pkg::GPIO_NUM-1:0] SUSP_LATCH_I,
  input wire logic DYN_SUSP_GPIO_EN_I,
  input wire logic DYN_SUSP_UART_EN_I,
  // Bus state from the function controller
  input wire logic USB_CONFIGURED_I,
  input wire logic USB_SUSPEND_I,
  input wire logic REMOTE_WAKE_EN_I,
  output logic RESUME_REQ_O,
  // Serial and modem control outputs passing through suspend logic
  input wire logic [hcpp_pkg::UART_NUM-1:0] UART_OUT_I,
  input wire logic [hcpp_pkg::UART_NUM-1:0] UART_SUSP_VAL_I,
  output logic [hcpp_pkg::UART_NUM-1:0] UART_OUT_O,
  // Serial activity and transceiver direction
  input wire logic TX_BYTE_I,
  input wire logic RX_BYTE_I,
  input wire logic XCVR_DIR_I,
  // Clock output shared with ring indicator
  input wire logic CLK_OUT_EN_I,
  input wire logic [hcpp_pkg::DIV_W-1:0] CLK_OUT_DIV_I,
  input wire logic RING_PIN_I,
  output logic RING_PIN_O,
  output logic RING_PIN_OE_N_O,
  output logic RING_INDICATOR_IN_O,
  // Battery charging
  input wire logic CHARGE_EN_I,
  input wire hcpp_pkg::hcpp_chg_t CHG_PORT_I,
  output logic CHARGE_BASE_LEVEL_OUT_O,
  output logic CHARGE_MID_LEVEL_OUT_O,
  output logic CHARGE_HIGH_LEVEL_OUT_O,
  // Pins
  input wire logic [hcpp_pkg::GPIO_NUM-1:0] GPIO_PIN_I,
  output logic [hcpp_pkg::GPIO_NUM-1:0] GPIO_PIN_O,
  output logic [hcpp_pkg::GPIO_NUM-1:0] GPIO_PIN_OE_N_O,
  output logic [hcpp_pkg::GPIO_NUM-1:0] GPIO_PULLUP_O
);
  import hcpp_pkg::*;

  // Output enable of a pad: low while driving
  function automatic logic pad_oe_n(input logic pp, input logic val);
    // Open-drain only drives a zero, push-pull drives both levels
    pad_oe_n = pp ? 1'b0 : val;
  endfunction : pad_oe_n

  // Pad output level; open-drain only ever drives low
  function automatic logic pad_out(input logic pp, input logic val);
    pad_out = pp ? val : 1'b0;
  endfunction : pad_out

  // Latch state
  hcpp_state_t st_reg; // Bus side state
  hcpp_state_t st_next;
  logic [GPIO_NUM-1:0] latch_reg; // Pin latches seen by the host
  logic [GPIO_NUM-1:0] latch_next;
  logic [GPIO_NUM-1:0] saved_reg; // Values held across suspend
  logic [GPIO_NUM-1:0] saved_next;
  logic gpio_sub_reg; // Pin latches substituted this suspend
  logic gpio_sub_next;
  logic uart_sub_reg; // Modem pins substituted this suspend
  logic uart_sub_next;
  logic [UART_NUM-1:0] uart_out_reg; // Registered modem outputs

  // Synchronised pin levels
  logic [GPIO_NUM-1:0] pin_level; // Filtered gpio levels
  logic ring_level; // Filtered ring pin level
  logic wake_prev_reg; // Last wake level for edge detection

  // Activity toggles
  logic [CNT_W-1:0] tick_cnt_reg; // Toggle rate divider
  logic tick; // One cycle per half toggle period
  logic [1:0] act_byte; // Byte events per channel
  logic [1:0] act_pend_reg; // Byte seen since last blink
  logic [1:0] act_tog_reg; // Toggle outputs, high at rest

  // Clock output
  logic [DIV_W-1:0] div_cnt_reg; // Half period counter
  logic clk_out_reg; // Divided clock
  logic clk_run; // Clock allowed to run

  // Pad drive
  logic [GPIO_NUM-1:0] alt_sel; // Pin carries its alternate
  logic [GPIO_NUM-1:0] alt_val; // Alternate function value
  logic [GPIO_NUM-1:0] drv_val; // Value presented to the pad
  logic [GPIO_NUM-1:0] drv_pp; // Effective push-pull mode
  logic [GPIO_NUM-1:0] pin_o_reg;
  logic [GPIO_NUM-1:0] pin_oe_n_reg;
  logic [GPIO_NUM-1:0] pullup_reg;
  logic ring_o_reg;
  logic ring_oe_n_reg;

  // Charger
  logic chg_live; // Charge outputs allowed
  logic chg_any; // A charging source is attached
  logic chg_dedicated; // Dedicated or charging downstream port
  logic chg_base_reg;
  logic chg_mid_reg;
  logic chg_high_reg;
  logic wake_fall; // Wake pin went active
  logic resume_reg;

  // Pin input synchronisers; pins float high at reset
  hcpp_sync3 #(
    .W(GPIO_NUM),
    .RST_VAL(LATCH_RST)
  ) u_gpio_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .d_i(GPIO_PIN_I),
    .level_o(pin_level)
  );

  hcpp_sync3 #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_ring_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .d_i(RING_PIN_I),
    .level_o(ring_level)
  );

  // Latch and suspend sequencing
  always_comb
  begin
    st_next = st_reg;
    latch_next = latch_reg;
    saved_next = saved_reg;
    gpio_sub_next = gpio_sub_reg;
    uart_sub_next = uart_sub_reg;
    case (st_reg)
      ST_BOOT:
      begin
        // Value chosen for the time right after reset
        latch_next = RESET_LATCH_I;
        st_next = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (USB_SUSPEND_I)
        begin
          st_next = ST_SUSPENDED;
          saved_next = latch_reg;
          // Substitution only on the configured-to-suspend step
          gpio_sub_next = USB_CONFIGURED_I & DYN_SUSP_GPIO_EN_I;
          uart_sub_next = USB_CONFIGURED_I & DYN_SUSP_UART_EN_I;
          if (USB_CONFIGURED_I && DYN_SUSP_GPIO_EN_I)
          begin
            latch_next = SUSP_LATCH_I;
          end
        end
        else if (LATCH_WR_I)
        begin
          // Host write; pace set by bus traffic only
          latch_next = LATCH_WDATA_I;
        end
      end
      ST_SUSPENDED:
      begin
        // Writes are ignored here so held latches stay put
        if (!USB_SUSPEND_I)
        begin
          st_next = ST_ACTIVE;
          latch_next = saved_reg;
          gpio_sub_next = 1'b0;
          uart_sub_next = 1'b0;
        end
      end
      default:
      begin
        st_next = ST_BOOT;
      end
    endcase
  end

  // Latch registers; reset holds every latch at one
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      st_reg <= ST_BOOT;
      latch_reg <= LATCH_RST;
      saved_reg <= LATCH_RST;
      gpio_sub_reg <= 1'b0;
      uart_sub_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      latch_reg <= latch_next;
      saved_reg <= saved_next;
      gpio_sub_reg <= gpio_sub_next;
      uart_sub_reg <= uart_sub_next;
    end
  end

  // Modem outputs take their suspend value while substituted
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      uart_out_reg <= UART_RST;
    end
    else if (uart_sub_reg)
    begin
      uart_out_reg <= UART_SUSP_VAL_I;
    end
    else
    begin
      uart_out_reg <= UART_OUT_I;
    end
  end

  // Shared rate divider; one blink speed for both LEDs
  assign tick = (tick_cnt_reg == TOGGLE_LAST);
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I || tick)
    begin
      tick_cnt_reg <= CNT_ZERO;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  assign act_byte = {RX_BYTE_I, TX_BYTE_I};

  // Each channel: low half then high half per burst of bytes
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_act
      always_ff @(posedge CLK_SYS_I)
      begin
        if (!RST_N_I)
        begin
          act_pend_reg[c] <= 1'b0;
          act_tog_reg[c] <= 1'b1;
        end
        else
        begin
          // A byte in the clearing cycle is kept for the next blink
          act_pend_reg[c] <= act_byte[c]
                           | (act_pend_reg[c] & ~(tick & act_tog_reg[c]));
          if (tick && (!act_tog_reg[c] || act_pend_reg[c]))
          begin
            act_tog_reg[c] <= ~act_tog_reg[c];
          end
        end
      end
    end
  endgenerate

  // Clock out halts in suspend so the pin goes quiet
  assign clk_run = CLK_OUT_EN_I & (st_reg != ST_SUSPENDED);
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I || !clk_run)
    begin
      div_cnt_reg <= DIV_ZERO;
      clk_out_reg <= 1'b0;
    end
    else if (div_cnt_reg == CLK_OUT_DIV_I)
    begin
      // Half period of divider plus one system cycles
      div_cnt_reg <= DIV_ZERO;
      clk_out_reg <= ~clk_out_reg;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // Alternate selection; pins 4 to 6 never carry one
  generate
    for (genvar p = 0; p < GPIO_NUM; p++)
    begin : g_pad
      if (p < ALT_NUM)
      begin : g_alt
        assign alt_sel[p] = ALT_EN_I[p];
      end
      else
      begin : g_plain
        assign alt_sel[p] = 1'b0;
      end
      // Inputs are plain open-drain ones; never pulled low
      assign drv_val[p] = alt_sel[p] ? alt_val[p] : latch_reg[p];
      assign drv_pp[p] = PP_MODE_I[p] & ~(alt_sel[p] && p == PIN_WAKE);
    end
  endgenerate

  assign alt_val[PIN_TX_ACT] = act_tog_reg[0];
  assign alt_val[PIN_RX_ACT] = act_tog_reg[1];
  assign alt_val[PIN_XCVR_DIR] = XCVR_DIR_I;
  assign alt_val[PIN_WAKE] = 1'b1; // Released so it can be read
  assign alt_val[GPIO_NUM-1:ALT_NUM] = '0;

  // Pad registers; reset leaves every pad released with pull-up
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      pin_o_reg <= '0;
      pin_oe_n_reg <= LATCH_RST;
      pullup_reg <= LATCH_RST;
      ring_o_reg <= 1'b0;
      ring_oe_n_reg <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < GPIO_NUM; i++)
      begin
        pin_o_reg[i] <= pad_out(drv_pp[i], drv_val[i]);
        pin_oe_n_reg[i] <= pad_oe_n(drv_pp[i], drv_val[i]);
      end
      pullup_reg <= ~drv_pp;
      // Shared ring pin: driven clock or released input
      ring_o_reg <= pad_out(CLK_OUT_EN_I, clk_out_reg);
      ring_oe_n_reg <= pad_oe_n(CLK_OUT_EN_I, 1'b1);
    end
  end

  // Charger classification from the detected port type
  assign chg_any = (CHG_PORT_I != CHG_NONE);
  assign chg_dedicated = (CHG_PORT_I == CHG_CDP)
                       | (CHG_PORT_I == CHG_DCP);
  // Standard port loses charge outputs while suspended
  assign chg_live = CHARGE_EN_I
                  & ~((st_reg == ST_SUSPENDED) && CHG_PORT_I == CHG_SDP);

  // Base 100 mA, mid 500 mA once configured or on a dedicated port, high 1.5 A
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      chg_base_reg <= 1'b0;
      chg_mid_reg <= 1'b0;
      chg_high_reg <= 1'b0;
    end
    else
    begin
      chg_base_reg <= chg_live & chg_any;
      chg_mid_reg <= chg_live
                   & (chg_dedicated | (chg_any & USB_CONFIGURED_I));
      chg_high_reg <= chg_live & chg_dedicated;
    end
  end

  // Wake pin going low while suspended asks for resume
  assign wake_fall = wake_prev_reg & ~pin_level[PIN_WAKE];
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      wake_prev_reg <= 1'b1;
      resume_reg <= 1'b0;
    end
    else
    begin
      wake_prev_reg <= pin_level[PIN_WAKE];
      resume_reg <= wake_fall & ALT_EN_I[PIN_WAKE] & REMOTE_WAKE_EN_I
                  & (st_reg == ST_SUSPENDED);
    end
  end

  // Outputs, all from registers
  assign LATCH_RDATA_O = latch_reg;
  assign PIN_LEVEL_O = pin_level;
  assign RESUME_REQ_O = resume_reg;
  assign UART_OUT_O = uart_out_reg;
  assign RING_PIN_O = ring_o_reg;
  assign RING_PIN_OE_N_O = ring_oe_n_reg;
  assign RING_INDICATOR_IN_O = ring_level;
  assign CHARGE_BASE_LEVEL_OUT_O = chg_base_reg;
  assign CHARGE_MID_LEVEL_OUT_O = chg_mid_reg;
  assign CHARGE_HIGH_LEVEL_OUT_O = chg_high_reg;
  assign GPIO_PIN_O = pin_o_reg;
  assign GPIO_PIN_OE_N_O = pin_oe_n_reg;
  assign GPIO_PULLUP_O = pullup_reg;
endmodule : hcpp_pin_port

// ===== bench/hcpp_pin_port_chk.sv
// Port-level assertions for the host controlled pin port
`timescale 1ns/1ps
module hcpp_pin_port_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic LATCH_WR_I,
  input wire logic [6:0] LATCH_WDATA_I,
  input wire logic [6:0] LATCH_RDATA_O,
  input wire logic [6:0] PIN_LEVEL_O,
  input wire logic [6:0] PP_MODE_I,
  input wire logic [3:0] ALT_EN_I,
  input wire logic [6:0] RESET_LATCH_I,
  input wire logic [6:0] SUSP_LATCH_I,
  input wire logic DYN_SUSP_GPIO_EN_I,
  input wire logic DYN_SUSP_UART_EN_I,
  input wire logic USB_CONFIGURED_I,
  input wire logic USB_SUSPEND_I,
  input wire logic REMOTE_WAKE_EN_I,
  input wire logic RESUME_REQ_O,
  input wire logic [3:0] UART_SUSP_VAL_I,
  input wire logic [3:0] UART_OUT_O,
  input wire logic CHARGE_EN_I,
  input wire hcpp_pkg::hcpp_chg_t CHG_PORT_I,
  input wire logic CHARGE_BASE_LEVEL_OUT_O,
  input wire logic CHARGE_MID_LEVEL_OUT_O,
  input wire logic CHARGE_HIGH_LEVEL_OUT_O,
  input wire logic [6:0] GPIO_PIN_O,
  input wire logic [6:0] GPIO_PIN_OE_N_O,
  input wire logic [6:0] GPIO_PULLUP_O
);
  import hcpp_pkg::*;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  logic susp_q; // Suspend seen last cycle
  logic [6:0] saved_reg; // Latches as they stood before suspend
  logic en_eff; // Charging enable after the standard-port cut
  logic [2:0] chg_exp; // Expected high, mid, base levels
  // A standard port loses its allowance in suspend; others keep it
  assign en_eff = CHARGE_EN_I && !(USB_SUSPEND_I && CHG_PORT_I == CHG_SDP);
  assign chg_exp[0] = en_eff && CHG_PORT_I != CHG_NONE;
  assign chg_exp[1] = en_eff && (CHG_PORT_I[1] ||
                      (USB_CONFIGURED_I && CHG_PORT_I == CHG_SDP));
  assign chg_exp[2] = en_eff && CHG_PORT_I[1];
  // Copy the latches on entry, before any substitution lands
  always_ff @(posedge CLK_SYS_I)
  begin
    susp_q <= RST_N_I && USB_SUSPEND_I;
    if (USB_SUSPEND_I && !susp_q)
      saved_reg <= LATCH_RDATA_O;
  end
  AST_RST_STATE: assert property (disable iff (1'b0)
    !RST_N_I |=> LATCH_RDATA_O == 7'h7f && GPIO_PIN_OE_N_O == 7'h7f
    && GPIO_PULLUP_O == 7'h7f) else $error("reset state wrong");
  AST_BOOT_LOAD: assert property ($rose(RST_N_I) |=>
    LATCH_RDATA_O == $past(RESET_LATCH_I)) else $error("boot value lost");
  AST_WRITE: assert property (LATCH_WR_I && !USB_SUSPEND_I &&
    !$past(USB_SUSPEND_I) && $past(RST_N_I) |=>
    LATCH_RDATA_O == $past(LATCH_WDATA_I)) else $error("write lost");
  AST_PAD_OE: assert property ($past(RST_N_I) |->
    GPIO_PIN_OE_N_O[6:4] == ($past(LATCH_RDATA_O[6:4]) &
    ~$past(PP_MODE_I[6:4]))) else $error("pad enable wrong");
  AST_PAD_DATA: assert property ($past(RST_N_I) |->
    GPIO_PIN_O[6:4] == ($past(LATCH_RDATA_O[6:4]) &
    $past(PP_MODE_I[6:4]))) else $error("pad data wrong");
  AST_SUSP_HOLD: assert property (USB_SUSPEND_I &&
    $past(USB_SUSPEND_I) && $past(USB_SUSPEND_I, 2) |->
    $stable(LATCH_RDATA_O)) else $error("latch moved in suspend");
  AST_DYN_ENTRY: assert property ($rose(USB_SUSPEND_I) &&
    $past(RST_N_I) |=> LATCH_RDATA_O == ($past(USB_CONFIGURED_I &&
    DYN_SUSP_GPIO_EN_I) ? $past(SUSP_LATCH_I) : $past(LATCH_RDATA_O)))
    else $error("suspend entry value wrong");
  AST_RESTORE: assert property ($fell(USB_SUSPEND_I) |=>
    LATCH_RDATA_O == saved_reg) else $error("latch not restored");
  AST_UART_SUB: assert property ($past(USB_SUSPEND_I, 2) &&
    $past(USB_SUSPEND_I) && $past(DYN_SUSP_UART_EN_I) |->
    UART_OUT_O == $past(UART_SUSP_VAL_I)) else $error("modem value wrong");
  AST_CHARGE: assert property ($past(RST_N_I) &&
    $past(USB_SUSPEND_I) == $past(USB_SUSPEND_I, 2) |->
    {CHARGE_HIGH_LEVEL_OUT_O, CHARGE_MID_LEVEL_OUT_O,
    CHARGE_BASE_LEVEL_OUT_O} == $past(chg_exp)) else $error("charge wrong");
  AST_WAKE: assert property ($fell(PIN_LEVEL_O[3]) && ALT_EN_I[3] &&
    REMOTE_WAKE_EN_I && USB_SUSPEND_I && $past(USB_SUSPEND_I) |=>
    RESUME_REQ_O) else $error("wake not reported");
  AST_WAKE_ONE: assert property (RESUME_REQ_O |->
    $past(USB_SUSPEND_I, 2) ##1 !RESUME_REQ_O)
    else $error("bad resume pulse");
  cover property ($fell(USB_SUSPEND_I));
  cover property (RESUME_REQ_O);
  cover property (CHARGE_HIGH_LEVEL_OUT_O);
endmodule : hcpp_pin_port_chk

// ===== bench/hcpp_board.sv
// Board beside the pin port: pull-ups, wake button, ring line
`timescale 1ns/1ps
module hcpp_board (
  input wire logic [6:0] pad_i,
  input wire logic [6:0] oe_n_i,
  input wire logic [6:0] pu_i,
  input wire logic ring_i,
  input wire logic ring_oe_n_i,
  input wire logic wake_n_i,
  output logic [6:0] level_o,
  output logic ring_o
);
  // Driven pad wins; a released pad floats to the pull-up, or else
  // shows the opposite of its last data so a stale value never passes
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      level_o[i] = !oe_n_i[i] ? pad_i[i] : (pu_i[i] | ~pad_i[i]);
    level_o[3] = level_o[3] & wake_n_i; // Button grounds the wake line
  end
  // Ring line has a board pull-up
  assign ring_o = !ring_oe_n_i ? ring_i : 1'b1;
endmodule : hcpp_board

// ===== bench/hcpp_pin_port_tb.sv
// Self-checking testbench for the host controlled pin port
`timescale 1ns/1ps
module hcpp_pin_port_tb;
  import hcpp_pkg::*;
  logic CLK_SYS_I = 1'b0, RST_N_I = 1'b0, LATCH_WR_I = 1'b0;
  logic [6:0] LATCH_WDATA_I = 7'h00, PP_MODE_I = 7'h70;
  logic [6:0] RESET_LATCH_I = 7'h35, SUSP_LATCH_I = 7'h0f;
  logic [3:0] ALT_EN_I = 4'h0, UART_OUT_I = 4'h5, UART_SUSP_VAL_I = 4'ha;
  logic DYN_SUSP_GPIO_EN_I = 1'b0, DYN_SUSP_UART_EN_I = 1'b0;
  logic USB_CONFIGURED_I = 1'b1, USB_SUSPEND_I = 1'b0;
  logic REMOTE_WAKE_EN_I = 1'b1, TX_BYTE_I = 1'b0, RX_BYTE_I = 1'b0;
  logic XCVR_DIR_I = 1'b1, CLK_OUT_EN_I = 1'b0, CHARGE_EN_I = 1'b1;
  logic [7:0] CLK_OUT_DIV_I = 8'h01;
  hcpp_chg_t CHG_PORT_I = CHG_NONE;
  logic [6:0] LATCH_RDATA_O, PIN_LEVEL_O, GPIO_PIN_I, GPIO_PIN_O;
  logic [6:0] GPIO_PIN_OE_N_O, GPIO_PULLUP_O;
  logic [3:0] UART_OUT_O;
  logic RESUME_REQ_O, RING_PIN_I, RING_PIN_O, RING_PIN_OE_N_O;
  logic RING_INDICATOR_IN_O, CHARGE_BASE_LEVEL_OUT_O;
  logic CHARGE_MID_LEVEL_OUT_O, CHARGE_HIGH_LEVEL_OUT_O;
  logic wake_n = 1'b1; // Wake button, low while pressed
  int mismatches = 0, checks_done = 0, cyc_cnt = 0;
  hcpp_pin_port u_dut (.*);
  hcpp_board u_board (.pad_i(GPIO_PIN_O), .oe_n_i(GPIO_PIN_OE_N_O),
    .pu_i(GPIO_PULLUP_O), .ring_i(RING_PIN_O),
    .ring_oe_n_i(RING_PIN_OE_N_O), .wake_n_i(wake_n),
    .level_o(GPIO_PIN_I), .ring_o(RING_PIN_I));
  initial
    forever #20 CLK_SYS_I = ~CLK_SYS_I;
  task automatic tk(input int n);
    repeat (n) @(posedge CLK_SYS_I);
  endtask : tk
  task automatic chk(input logic [6:0] v, input logic [6:0] e);
    checks_done++;
    if (v !== e)
    begin
      mismatches++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, v, e);
    end
  endtask : chk
  // One host latch write, strobe high for a single edge
  task automatic wr(input logic [6:0] d);
    LATCH_WR_I <= 1'b1;
    LATCH_WDATA_I <= d;
    tk(1);
    LATCH_WR_I <= 1'b0;
  endtask : wr
  // Expected {high, mid, base} for a port type, configured bus
  function automatic logic [6:0] chg(input int p, input int s);
    if (p == 0 || (s == 1 && p == 1))
      return 7'h00;
    return (p == 1) ? 7'h03 : 7'h07;
  endfunction : chg
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge CLK_SYS_I)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    int n;
    logic prev;
    tk(20);
    RST_N_I <= 1'b1;
    #1 chk(LATCH_RDATA_O, 7'h7f);
    chk(GPIO_PIN_OE_N_O & GPIO_PULLUP_O, 7'h7f);
    tk(1);
    #1 chk(LATCH_RDATA_O, 7'h35);
    $display("test reset done");
    tk(1);
    LATCH_WR_I <= 1'b1;
    LATCH_WDATA_I <= 7'h55;
    tk(1);
    #1 chk(LATCH_RDATA_O, 7'h55);
    wr(7'h2a);
    #1 chk(LATCH_RDATA_O, 7'h2a);
    tk(1);
    #1 chk(GPIO_PIN_OE_N_O, 7'h0a);
    chk(GPIO_PIN_O, 7'h20);
    tk(6); // Pin reads lag by the filter, not real time
    #1 chk(PIN_LEVEL_O, 7'h2a);
    USB_SUSPEND_I <= 1'b1;
    tk(3);
    wr(7'h11);
    #1 chk(LATCH_RDATA_O, 7'h2a);
    chk(7'(UART_OUT_O), 7'h05);
    USB_SUSPEND_I <= 1'b0;
    DYN_SUSP_GPIO_EN_I <= 1'b1;
    DYN_SUSP_UART_EN_I <= 1'b1;
    tk(3);
    USB_SUSPEND_I <= 1'b1;
    tk(2);
    #1 chk(LATCH_RDATA_O, 7'h0f);
    chk(7'(UART_OUT_O), 7'h0a);
    USB_SUSPEND_I <= 1'b0;
    tk(2);
    #1 chk(LATCH_RDATA_O, 7'h2a);
    chk(7'(UART_OUT_O), 7'h05);
    DYN_SUSP_UART_EN_I <= 1'b0;
    USB_CONFIGURED_I <= 1'b0;
    tk(2);
    USB_SUSPEND_I <= 1'b1;
    tk(3);
    #1 chk(LATCH_RDATA_O, 7'h2a);
    chk(7'(UART_OUT_O), 7'h05);
    USB_CONFIGURED_I <= 1'b1;
    $display("test suspend done");
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 4; p++)
      begin
        tk(1);
        USB_SUSPEND_I <= s[0];
        CHG_PORT_I <= hcpp_chg_t'(p);
        tk(3);
        #1 chk(7'({CHARGE_HIGH_LEVEL_OUT_O, CHARGE_MID_LEVEL_OUT_O,
          CHARGE_BASE_LEVEL_OUT_O}), chg(p, s));
      end
    CHARGE_EN_I <= 1'b0;
    ALT_EN_I <= 4'h8;
    tk(3);
    #1 chk(7'(CHARGE_BASE_LEVEL_OUT_O), 7'h00);
    chk(7'(GPIO_PIN_OE_N_O[3]), 7'h01);
    $display("test charge done");
    for (int w = 1; w >= 0; w--)
    begin
      REMOTE_WAKE_EN_I <= w[0];
      wake_n <= 1'b0;
      n = 0;
      repeat (20)
      begin
        tk(1);
        #1 if (RESUME_REQ_O === 1'b1) n++;
      end
      chk(7'(n), 7'(w));
      wake_n <= 1'b1;
      tk(10);
    end
    USB_SUSPEND_I <= 1'b0;
    ALT_EN_I <= 4'h7;
    tk(8);
    #1 chk(7'(GPIO_PIN_I[2:0]), 7'h07);
    XCVR_DIR_I <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      TX_BYTE_I <= (i == 0);
      RX_BYTE_I <= (i == 1);
      tk(1);
      TX_BYTE_I <= 1'b0;
      RX_BYTE_I <= 1'b0;
      for (n = 0; GPIO_PIN_I[i] !== 1'b0 && n < 1100; n++)
        tk(1);
      chk(7'(n < 1100), 7'h01);
      for (n = 0; GPIO_PIN_I[i] !== 1'b1 && n < 600; n++)
        tk(1);
      chk(7'(n > 494 && n < 506), 7'h01);
      #1 chk(7'(GPIO_PIN_I[2]), 7'h00);
    end
    $display("test alternates done");
    CLK_OUT_EN_I <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      USB_SUSPEND_I <= s[0];
      tk(6);
      n = 0;
      repeat (40)
      begin
        prev = RING_PIN_I;
        tk(1);
        #1 if (RING_PIN_I !== prev) n++;
      end
      chk(7'(s ? n == 0 : n > 18 && n < 22), 7'h01);
    end
    // Stopped clock holds the shared pin low, seen on the ring input
    chk(7'(RING_INDICATOR_IN_O), 7'h00);
    CLK_OUT_EN_I <= 1'b0;
    tk(6);
    #1 chk(7'(RING_INDICATOR_IN_O), 7'h01);
    $display("test clock out done");
    give_verdict();
  end
endmodule : hcpp_pin_port_tb
bind hcpp_pin_port hcpp_pin_port_chk u_chk (.*);
